// ===== logic/sbc_pkg.sv
package sbc_pkg;

	// Organisation: four byte lanes of nine bits, 256K words.
	localparam int SBC_LANES = 4;
	localparam int SBC_LANE_W = 9;
	localparam int SBC_DATA_W = SBC_LANES * SBC_LANE_W;
	localparam int SBC_ADDR_W = 18;
	localparam int SBC_DEPTH = 262144;
	localparam int SBC_BURST_W = 2;

	// Reset values of the control state.
	localparam logic [SBC_BURST_W-1:0] SBC_CNT_RST = 2'h0;
	localparam logic [SBC_LANES-1:0] SBC_LANES_OFF = 4'h0;
	localparam logic [SBC_DATA_W-1:0] SBC_DATA_RST = 36'h0_0000_0000;

	// Synchronous control strobes, all active low.
	typedef struct packed {
		logic chip_select_n;
		logic proc_addr_strobe_n;
		logic ctrl_addr_strobe_n;
		logic burst_advance_n;
	} sbc_strobe_t;

	// Write controls, all active low; lane_sel_n[0] is lane a.
	typedef struct packed {
		logic all_lane_write_n;
		logic lane_write_qualify_n;
		logic [SBC_LANES-1:0] lane_sel_n;
	} sbc_write_t;

	// Asynchronous pins and mode straps, sampled through two flops.
	typedef struct packed {
		logic output_enable_n;
		logic sleep_request;
		logic burst_order_select_n;
		logic flow_select_n;
	} sbc_mode_t;

	typedef enum logic [1:0] {
		SBC_OP_DESELECT,
		SBC_OP_LOAD,
		SBC_OP_NEXT,
		SBC_OP_HOLD
	} sbc_op_t;

endpackage

// ===== logic/sbc_burst_count.sv
`timescale 1ns/10ps
module sbc_burst_count (
	// Clock and control.
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic clk_en,
	// Counter commands.
	input wire logic load,
	input wire logic advance,
	input wire logic interleave,
	input wire logic [sbc_pkg::SBC_BURST_W-1:0] start,
	// Low address bits for this cycle.
	output logic [sbc_pkg::SBC_BURST_W-1:0] cur_addr,
	output logic [sbc_pkg::SBC_BURST_W-1:0] next_addr
);
	import sbc_pkg::*;

	logic [SBC_BURST_W-1:0] start_reg;
	logic [SBC_BURST_W-1:0] start_next;
	logic [SBC_BURST_W-1:0] cnt_reg;
	logic [SBC_BURST_W-1:0] cnt_next;
	logic [SBC_BURST_W-1:0] cnt_step;

	// Both orders are the start value combined with a 2-bit count.
	function automatic logic [SBC_BURST_W-1:0] order(input logic [SBC_BURST_W-1:0] s,
			input logic [SBC_BURST_W-1:0] c, input logic il);
		if (il) begin
			order = s ^ c;
		end else begin
			order = s + c;
		end
	endfunction

	// Count wraps modulo four, so the fourth step returns to the start.
	always_comb begin
		cnt_step = cnt_reg + 2'h1;
		start_next = start_reg;
		cnt_next = cnt_reg;
		if (load) begin
			start_next = start;
			cnt_next = SBC_CNT_RST;
		end else if (advance) begin
			cnt_next = cnt_step;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			start_reg <= SBC_CNT_RST;
			cnt_reg <= SBC_CNT_RST;
		end else if (clk_en) begin
			start_reg <= start_next;
			cnt_reg <= cnt_next;
		end
	end

	// Order is applied on output, so changing it mid-burst reorders the rest.
	assign cur_addr = order(start_reg, cnt_reg, interleave);
	assign next_addr = order(start_reg, cnt_step, interleave);

endmodule

// ===== logic/sbc_array.sv
`timescale 1ns/10ps
module sbc_array (
	// Clock.
	input wire logic ref_clk,
	input wire logic clk_en,
	// One access per cycle.
	input wire logic [sbc_pkg::SBC_ADDR_W-1:0] addr,
	input wire logic [sbc_pkg::SBC_LANES-1:0] lane_we,
	input wire logic [sbc_pkg::SBC_DATA_W-1:0] wdata,
	output logic [sbc_pkg::SBC_DATA_W-1:0] rdata
);
	import sbc_pkg::*;

	logic [SBC_DATA_W-1:0] mem [SBC_DEPTH];
	logic [SBC_DATA_W-1:0] rdata_next;

	// Read data is registered; the array itself carries no reset.
	always_comb begin
		rdata_next = mem[addr];
	end

	always_ff @(posedge ref_clk) begin
		if (clk_en) begin
			rdata <= rdata_next;
		end
	end

	// Each lane has its own write strobe, unselected lanes keep their contents.
	for (genvar g = 0; g < SBC_LANES; g++) begin : g_lane
		always_ff @(posedge ref_clk) begin
			if (clk_en && lane_we[g]) begin
				mem[addr][g*SBC_LANE_W +: SBC_LANE_W] <= wdata[g*SBC_LANE_W +: SBC_LANE_W];
			end
		end
	end

endmodule

// ===== logic/sbc_top.sv
`timescale 1ns/10ps
// Functional notes
// - Sleep high means standby; floating means active
// - Low burst order: linear modulo-four stepping
// - High burst order: start XOR count
// - Select and processor strobe: load, read
// - Select, controller strobe: load, write or read
// - Deselected with controller strobe: data off
// - No strobe, advance low: step counter
// - No strobe, advance high: hold counter
// - Byte write writes lanes selected low
// - No lane selected means read cycle
// - Global write low writes every lane
// - Reads drive all byte lanes
// - Writes keep every lane undriven
// - Lanes c and d in 36-bit organisation
// - Output enable only gates active drivers
// - Dummy reads step counter like reads
// - Flow select low flow-through, high pipelined
module sbc_top (
	// Clock, reset and clock enable.
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic clk_en,
	// Address and synchronous controls from the controller.
	input wire logic [sbc_pkg::SBC_ADDR_W-1:0] addr,
	input wire sbc_pkg::sbc_strobe_t strobes,
	input wire sbc_pkg::sbc_write_t write_ctl,
	// Asynchronous pins and mode straps.
	input wire sbc_pkg::sbc_mode_t mode_pins,
	// Data bus, split into input, output and per-lane enable.
	input wire logic [sbc_pkg::SBC_DATA_W-1:0] dq_in,
	output logic [sbc_pkg::SBC_DATA_W-1:0] dq_out,
	output logic [sbc_pkg::SBC_LANES-1:0] dq_oe,
	// Status.
	output logic standby
);
	import sbc_pkg::*;

	// Two-flop samplers for the asynchronous pins.
	sbc_mode_t mode_s1_reg;
	sbc_mode_t mode_s1_next;
	sbc_mode_t mode_reg;
	sbc_mode_t mode_next;

	// Decoded command of this cycle.
	sbc_op_t op;
	logic cs_active;
	logic is_write;
	logic is_access;
	logic [SBC_LANES-1:0] lane_we;
	logic [SBC_ADDR_W-1:0] acc_addr;
	logic cnt_load;
	logic cnt_adv;
	logic [SBC_BURST_W-1:0] cur_low;
	logic [SBC_BURST_W-1:0] next_low;
	logic [SBC_DATA_W-1:0] mem_rdata;

	// Upper address of the running burst.
	logic [SBC_ADDR_W-1:SBC_BURST_W] hi_reg;
	logic [SBC_ADDR_W-1:SBC_BURST_W] hi_next;

	// Read return pipeline.
	logic rd1_reg;
	logic rd1_next;
	logic rd2_reg;
	logic rd2_next;
	logic [SBC_DATA_W-1:0] pipe_reg;
	logic [SBC_DATA_W-1:0] pipe_next;
	logic [SBC_DATA_W-1:0] dq_out_next;
	logic [SBC_LANES-1:0] dq_oe_next;
	logic read_live_reg;
	logic read_live_next;
	logic standby_next;

	// Lanes written by one cycle's write controls.
	function automatic logic [SBC_LANES-1:0] lanes_written(input sbc_write_t w);
		if (!w.all_lane_write_n) begin
			lanes_written = {SBC_LANES{1'b1}};
		end else if (!w.lane_write_qualify_n) begin
			lanes_written = ~w.lane_sel_n;
		end else begin
			lanes_written = SBC_LANES_OFF;
		end
	endfunction

	// Asynchronous pins pass two flops; only the second is read.
	always_comb begin
		mode_s1_next = mode_pins;
		mode_next = mode_s1_reg;
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			mode_s1_reg <= '0;
			mode_reg <= '0;
		end else if (clk_en) begin
			mode_s1_reg <= mode_s1_next;
			mode_reg <= mode_next;
		end
	end

	// Command decode. Sleep overrides everything and acts as a deselect,
	// so a sleeping part neither writes nor drives the bus.
	always_comb begin
		cs_active = !strobes.chip_select_n;
		lane_we = SBC_LANES_OFF;
		is_write = 1'b0;
		op = SBC_OP_HOLD;
		if (mode_reg.sleep_request) begin
			op = SBC_OP_DESELECT;
		end else if (cs_active && !strobes.proc_addr_strobe_n) begin
			op = SBC_OP_LOAD;
		end else if (cs_active && !strobes.ctrl_addr_strobe_n) begin
			op = SBC_OP_LOAD;
			lane_we = lanes_written(write_ctl);
		end else if (!cs_active && !strobes.ctrl_addr_strobe_n) begin
			op = SBC_OP_DESELECT;
		end else if (!strobes.burst_advance_n) begin
			op = SBC_OP_NEXT;
			lane_we = lanes_written(write_ctl);
		end else begin
			op = SBC_OP_HOLD;
			lane_we = lanes_written(write_ctl);
		end
		is_write = |lane_we;
	end

	// Counter control and the address used by this cycle.
	always_comb begin
		cnt_load = 1'b0;
		cnt_adv = 1'b0;
		is_access = 1'b1;
		hi_next = hi_reg;
		acc_addr = {hi_reg, cur_low};
		case (op)
			SBC_OP_DESELECT: begin
				is_access = 1'b0;
			end
			SBC_OP_LOAD: begin
				cnt_load = 1'b1;
				hi_next = addr[SBC_ADDR_W-1:SBC_BURST_W];
				acc_addr = addr;
			end
			SBC_OP_NEXT: begin
				// Output enable plays no part here, dummy reads step too.
				cnt_adv = 1'b1;
				acc_addr = {hi_reg, next_low};
			end
			SBC_OP_HOLD: begin
				acc_addr = {hi_reg, cur_low};
			end
			default: begin
				is_access = 1'b0;
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			hi_reg <= '0;
		end else if (clk_en) begin
			hi_reg <= hi_next;
		end
	end

	sbc_burst_count u_count (
		.ref_clk(ref_clk),
		.rst(rst),
		.clk_en(clk_en),
		.load(cnt_load),
		.advance(cnt_adv),
		.interleave(mode_reg.burst_order_select_n),
		.start(addr[SBC_BURST_W-1:0]),
		.cur_addr(cur_low),
		.next_addr(next_low)
	);

	// Write data is taken on the same edge as the write command.
	sbc_array u_array (
		.ref_clk(ref_clk),
		.clk_en(clk_en),
		.addr(acc_addr),
		.lane_we(lane_we),
		.wdata(dq_in),
		.rdata(mem_rdata)
	);

	// Read return. The array answers one edge after the command; pipeline
	// mode adds one more output register. A write or sleep clears the
	// read marker, so drivers drop in the cycle the data would have shown.
	always_comb begin
		rd1_next = is_access && !is_write;
		rd2_next = rd1_reg;
		pipe_next = mem_rdata;
		read_live_next = read_live_reg;
		dq_out_next = dq_out;
		if (mode_reg.flow_select_n) begin
			read_live_next = rd2_reg;
			if (rd2_reg) begin
				dq_out_next = pipe_reg;
			end
		end else begin
			read_live_next = rd1_reg;
			if (rd1_reg) begin
				dq_out_next = mem_rdata;
			end
		end
		if (is_write) begin
			read_live_next = 1'b0;
		end
		if (mode_reg.sleep_request) begin
			read_live_next = 1'b0;
		end
		// Output enable gates drivers but never creates a read; since it is
		// sampled, turn-off lags the pin by the sampler delay.
		if (read_live_next && !mode_reg.output_enable_n) begin
			dq_oe_next = {SBC_LANES{1'b1}};
		end else begin
			dq_oe_next = SBC_LANES_OFF;
		end
		standby_next = mode_reg.sleep_request;
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			rd1_reg <= 1'b0;
			rd2_reg <= 1'b0;
			pipe_reg <= SBC_DATA_RST;
			read_live_reg <= 1'b0;
			dq_out <= SBC_DATA_RST;
			dq_oe <= SBC_LANES_OFF;
			standby <= 1'b0;
		end else if (clk_en) begin
			rd1_reg <= rd1_next;
			rd2_reg <= rd2_next;
			pipe_reg <= pipe_next;
			read_live_reg <= read_live_next;
			dq_out <= dq_out_next;
			dq_oe <= dq_oe_next;
			standby <= standby_next;
		end
	end

endmodule

// ===== tb/sbc_top_asserts.sv
`timescale 1ns/10ps
module sbc_top_asserts (
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic clk_en,
	// Watched inputs.
	input wire sbc_pkg::sbc_strobe_t strobes,
	input wire sbc_pkg::sbc_write_t write_ctl,
	input wire sbc_pkg::sbc_mode_t mode_pins,
	// Watched outputs.
	input wire logic [sbc_pkg::SBC_LANES-1:0] dq_oe,
	input wire logic standby
);
	import sbc_pkg::*;
	logic rd, ds, wr, ok, steady, flow_reg;
	logic [1:0] calm_reg, calm_next;
	// Decoded command of this cycle.
	assign rd = clk_en && !strobes.chip_select_n && !strobes.proc_addr_strobe_n;
	assign ds = clk_en && strobes.chip_select_n && !strobes.ctrl_addr_strobe_n;
	assign wr = clk_en && !rd && !ds && (!write_ctl.all_lane_write_n
		|| (!write_ctl.lane_write_qualify_n && write_ctl.lane_sel_n != 4'hf));
	assign ok = clk_en && !mode_pins.output_enable_n && !mode_pins.sleep_request;
	assign steady = ok && calm_reg == 2'h3 && mode_pins.flow_select_n == flow_reg;
	// Mode pins pass two flops, so a fixed latency holds only in a settled window.
	always_comb begin
		calm_next = calm_reg + 2'h1;
		if (rst || !ok || mode_pins.flow_select_n != flow_reg)
			calm_next = 2'h0;
		else if (calm_reg == 2'h3)
			calm_next = 2'h3;
	end
	always_ff @(posedge ref_clk) begin
		calm_reg <= calm_next;
		flow_reg <= mode_pins.flow_select_n;
	end
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);
	sequence s_rd_flow;
		steady && !mode_pins.flow_select_n && rd ##1 clk_en && !wr;
	endsequence
	sequence s_rd_pipe;
		steady && mode_pins.flow_select_n && rd ##1 (clk_en && !wr)[*2];
	endsequence
	property p_lanes;
		dq_oe == 4'h0 || dq_oe == 4'hf;
	endproperty
	property p_wr_off;
		wr |=> dq_oe == 4'h0;
	endproperty
	property p_desel;
		ds ##1 ds ##1 clk_en |=> dq_oe == 4'h0;
	endproperty
	property p_oe_off;
		(clk_en && mode_pins.output_enable_n)[*3] |=> dq_oe == 4'h0;
	endproperty
	property p_sleep_on;
		(clk_en && mode_pins.sleep_request)[*3] |=> standby;
	endproperty
	property p_sleep_off;
		(clk_en && !mode_pins.sleep_request)[*3] |=> !standby;
	endproperty
	property p_flow_rd;
		s_rd_flow |=> dq_oe == 4'hf;
	endproperty
	property p_pipe_rd;
		s_rd_pipe |=> dq_oe == 4'hf;
	endproperty
	a_lanes: assert property (p_lanes) else $error("lane enables differ");
	a_wr_off: assert property (p_wr_off) else $error("driving after write");
	a_desel: assert property (p_desel) else $error("driving when deselected");
	a_oe_off: assert property (p_oe_off) else $error("driving with oe high");
	a_sleep_on: assert property (p_sleep_on) else $error("no standby");
	a_sleep_off: assert property (p_sleep_off) else $error("stuck in standby");
	a_flow_rd: assert property (p_flow_rd) else $error("flow read late");
	a_pipe_rd: assert property (p_pipe_rd) else $error("pipeline read late");
endmodule

bind sbc_top sbc_top_asserts u_chk (.ref_clk, .rst, .clk_en, .strobes, .write_ctl,
	.mode_pins, .dq_oe, .standby);

// ===== tb/sbc_ctl_model.sv
`timescale 1ns/10ps
module sbc_ctl_model (
	// Clock and device status.
	input wire logic ref_clk,
	input wire logic [sbc_pkg::SBC_LANES-1:0] dq_oe,
	// Synchronous bus toward the device.
	output logic [sbc_pkg::SBC_ADDR_W-1:0] addr,
	output sbc_pkg::sbc_strobe_t strobes,
	output sbc_pkg::sbc_write_t write_ctl,
	output logic [sbc_pkg::SBC_DATA_W-1:0] dq_in
);
	import sbc_pkg::*;
	logic wr;
	int n;
	// Idle bus: deselected, no write.
	initial begin
		addr = 18'h0_0000;
		strobes = 4'hd;
		write_ctl = 6'h3f;
		dq_in = 36'h0_0000_0000;
	end
	// One bus cycle, launched after a falling edge and held for the whole cycle.
	task automatic op(input logic [3:0] s, input logic [5:0] w, input logic [17:0] a,
		input logic [35:0] d);
		wr = !(!s[3] && !s[2]) && !(s[3] && !s[1]) && (!w[5] || (!w[4] && w[3:0] != 4'hf));
		n = 0;
		@(negedge ref_clk);
		// Write data must not meet live read drivers, so wait for them to let go.
		while (wr && dq_oe !== 4'h0 && n < 8) begin
			n++;
			@(negedge ref_clk);
		end
		strobes <= s;
		write_ctl <= w;
		addr <= a;
		dq_in <= wr ? d : ~dq_in;
	endtask
endmodule

// ===== tb/tb_top.sv
`timescale 1ns/10ps
module tb_top;
	import sbc_pkg::*;
	localparam logic [3:0] RDP = 4'h3, CTL = 4'h5, NXT = 4'he, HLD = 4'h7, DES = 4'hd;
	localparam logic [5:0] W_ALL = 6'h1f, W_NONE = 6'h3f;
	localparam logic [17:0] H = 18'h2_5a34;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic clk_en = 1'b1;
	sbc_mode_t mode_pins = 4'h0;
	logic [17:0] addr;
	sbc_strobe_t strobes;
	sbc_write_t write_ctl;
	logic [35:0] dq_in, dq_out, m;
	logic [3:0] dq_oe;
	logic standby, isw;
	logic [39:0] q[$];
	logic [39:0] e;
	logic [4:0] tbl [7] = '{5'h0e, 5'h0d, 5'h0b, 5'h07, 5'h00, 5'h0f, 5'h10};
	int error_cnt = 0, samples_checked = 0, lat = 2, i, j;
	always #4 ref_clk = ~ref_clk;
	sbc_top dut (.ref_clk, .rst, .clk_en, .addr, .strobes, .write_ctl, .mode_pins,
		.dq_in, .dq_out, .dq_oe, .standby);
	sbc_ctl_model ctl (.ref_clk, .dq_oe, .addr, .strobes, .write_ctl, .dq_in);
	// Word pattern unique to each low address.
	function automatic logic [35:0] pat(input logic [1:0] b);
		return {H[17:2], b, ~H[17:2], ~b};
	endfunction
	task automatic chk_d(input logic [35:0] g, input logic [35:0] x);
		samples_checked++;
		if (g !== x) begin
			error_cnt++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, x);
		end
	endtask
	task automatic chk_b(input logic [3:0] g, input logic [3:0] x);
		samples_checked++;
		if (g !== x) begin
			error_cnt++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, x);
		end
	endtask
	// Issue one cycle and check the cycle issued lat cycles earlier.
	task automatic go(input logic [3:0] s, input logic [5:0] w, input logic [1:0] b,
		input logic [35:0] d, input logic [3:0] eo, input logic [35:0] x);
		ctl.op(s, w, {H[17:2], b}, d);
		q.push_back({eo, x});
		if (q.size() > lat) begin
			e = q.pop_front();
			chk_b(dq_oe, e[39:36]);
			if (e[39]) chk_d(dq_out, e[35:0]);
		end
	endtask
	// Deselects carry a write and data, which must be ignored.
	task automatic des(input int k);
		repeat (k) go(DES, W_ALL, 2'h0, '1, 4'h0, '0);
	endtask
	task automatic done(input string t);
		des(3);
		$display("test %s finished", t);
	endtask
	task automatic conclude();
		$display("compares %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// A hang is cut off well past the expected run of under one microsecond.
	initial begin
		#20000;
		error_cnt++;
		conclude();
	end
	initial begin
		repeat (5) @(negedge ref_clk);
		rst = 1'b0;
		chk_b({3'h0, standby}, 4'h0);
		done("reset");
		go(CTL, W_ALL, 2'h1, pat(2'h1), 4'h0, '0);
		for (i = 2; i < 5; i++) go(NXT, W_ALL, 2'h0, pat(i[1:0]), 4'h0, '0);
		for (i = 0; i < 4; i++) go(CTL, W_NONE, i[1:0], '0, 4'hf, pat(i[1:0]));
		done("linear write");
		go(4'h1, W_ALL, 2'h2, '1, 4'hf, pat(2'h2));
		for (i = 3; i < 7; i++) go(NXT, W_NONE, 2'h0, '0, 4'hf, pat(i[1:0]));
		go(HLD, W_NONE, 2'h0, '0, 4'hf, pat(2'h2));
		done("linear read");
		mode_pins.output_enable_n = 1'b1;
		des(3);
		repeat (2) go(NXT, W_NONE, 2'h0, '0, 4'h0, '0);
		mode_pins.output_enable_n = 1'b0;
		des(3);
		go(HLD, W_NONE, 2'h0, '0, 4'hf, pat(2'h0));
		done("dummy read");
		mode_pins.burst_order_select_n = 1'b1;
		des(3);
		go(RDP, W_NONE, 2'h1, '0, 4'hf, pat(2'h1));
		for (i = 1; i < 5; i++) go(NXT, W_NONE, 2'h0, '0, 4'hf, pat(2'h1 ^ i[1:0]));
		done("interleaved");
		m = pat(2'h0);
		for (i = 0; i < 7; i++) begin
			des(2);
			isw = !tbl[i][4] && tbl[i][3:0] != 4'hf;
			go(CTL, {1'b1, tbl[i]}, 2'h0, ~m, isw ? 4'h0 : 4'hf, m);
			for (j = 0; j < 4; j++)
				if (isw && !tbl[i][j]) m[9*j +: 9] = ~m[9*j +: 9];
			go(RDP, W_NONE, 2'h0, '0, 4'hf, m);
		end
		done("lanes");
		// A write taken while the clock enable is low must be dropped entirely.
		clk_en = 1'b0;
		go(CTL, W_ALL, 2'h0, ~m, 4'h0, '0);
		des(1);
		clk_en = 1'b1;
		des(2);
		go(RDP, W_NONE, 2'h0, '0, 4'hf, m);
		mode_pins.sleep_request = 1'b1;
		des(3);
		go(CTL, W_ALL, 2'h0, ~m, 4'h0, '0);
		chk_b({3'h0, standby}, 4'h1);
		mode_pins.sleep_request = 1'b0;
		des(3);
		go(RDP, W_NONE, 2'h0, '0, 4'hf, m);
		done("sleep");
		mode_pins.flow_select_n = 1'b1;
		des(3);
		lat = 3;
		go(RDP, W_NONE, 2'h0, '0, 4'hf, m);
		go(CTL, W_NONE, 2'h3, '0, 4'hf, pat(2'h3));
		go(HLD, W_NONE, 2'h0, '0, 4'hf, pat(2'h3));
		done("pipeline");
		conclude();
	end
endmodule
